// file: hdl/lmpcs_chip_select.sv
// Purpose: lower, mid-range and peripheral chip-select decode with waits
// Assumes: processor address and cycle qualifiers come from the aclk domain
// Notes:   selects are registered, one cycle behind the sampled address
//
// Notes on behaviour
// R1: lower select armed by any access to its register
// R2: software programs lower range before using it
// R3: lower size code picks 64K to 512K from zero
// R4: address-phase suppress honoured only with strap high
// R5: pseudo-static ram support follows lower register bit
// R6: refresh unit configured before pseudo-static enable
// R7: ready-ignore bit drops external ready per group
// R8: two-bit wait code gives zero to three waits
// R9: mid selects armed after both registers accessed
// R10: mid base bits give address bits 19-13
// R11: mid base is multiple of block size
// R12: mid base zero only without lower select
// R13: one-hot mid size; quarters map selects 0-3
// R14: pin-function bit swaps pins 6,5 with A2,A1
// R15: space bit picks memory or io cycles
// R16: io peripheral decode limited to 64K
// R17: peripheral base bits 19-11, fixed windows above
// R18: io peripheral base keeps top four bits zero
// R19: three-bit peripheral wait code up to fifteen
// R20: external ready high stretches the data phase
// R21: narrow-bus bit picks 8-bit mid/peripheral cycles
// R22: selects active low for whole matching cycle
// R23: reserved bits read fixed, writes ignored
`timescale 1ns/1ps
module lmpcs_chip_select
  import lmpcs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [19:0] cpu_addr,
  input  wire logic        cpu_cycle_active,
  input  wire logic        cpu_is_memory,
  input  wire logic        address_enable_strap,
  input  wire logic        async_ready_in,
  input  wire logic        sync_ready_in,
  output logic             low_mem_select_n,
  output logic [3:0]       mid_mem_selects_n,
  output logic [3:0]       periph_selects_n,
  output logic [1:0]       periph_pin65,
  output logic [3:0]       wait_count,
  output logic             ext_wait_hold,
  output logic             addr_phase_off,
  output logic             psram_mode_enable,
  output logic             mid_periph_narrow_bus
);

  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [15:0] low_cfg;
    logic [15:0] per_cfg;
    logic [15:0] mid_cfg;
    logic [15:0] aux_cfg;
    logic        narrow;
    logic        low_armed;
    logic        mid_seen;
    logic        aux_seen;
    logic        per_armed;
    logic [2:0]  strap_sync;
    logic [1:0]  strap_cnt;
    logic        strap_taken;
    logic        strap_high;
    logic [2:0]  rdy_sync;
    logic        rdy_level;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        low_n;
    logic [3:0]  mid_n;
    logic [3:0]  per_n;
    logic [1:0]  pin65;
    logic [3:0]  waits;
    logic        hold;
    logic        apoff;
    logic        narrow_out;
  } lmpcs_state_t;

  lmpcs_state_t cur_ff;
  lmpcs_state_t nxt_cur;

  // ****************
  // helpers
  // ****************
  // peripheral 0-3 wait code to wait count
  function automatic logic [3:0] per_waits(input logic [2:0] code);
    case (code)
      3'h4:    per_waits = 4'h5;
      3'h5:    per_waits = 4'h7;
      3'h6:    per_waits = 4'h9;
      3'h7:    per_waits = 4'hF;
      default: per_waits = {2'h0, code[1:0]};
    endcase
  endfunction

  // quarter index inside a one-hot mid block
  function automatic logic [1:0] mid_quarter(input logic [6:0] size,
                                             input logic [19:0] a);
    logic [1:0] q;
    q = 2'h0;
    for (int i = 0; i < 7; i++) begin
      if (size[i]) begin
        q = a[12+i -: 2];
      end
    end
    mid_quarter = q;
  endfunction

  // register read value with reserved bits fixed
  function automatic logic [15:0] reg_view(input lmpcs_state_t s,
                                           input logic [11:0] a);
    case (a)
      LMPCS_ADDR_LOW:  reg_view = (s.low_cfg & LMPCS_LOW_WMASK)
                                  | LMPCS_LOW_FIXED; // R23
      LMPCS_ADDR_PER:  reg_view = (s.per_cfg & LMPCS_PER_WMASK)
                                  | LMPCS_PER_FIXED; // R23
      LMPCS_ADDR_MID:  reg_view = (s.mid_cfg & LMPCS_MID_WMASK)
                                  | LMPCS_MID_FIXED; // R23
      LMPCS_ADDR_AUX:  reg_view = (s.aux_cfg & LMPCS_AUX_WMASK)
                                  | LMPCS_AUX_FIXED; // R23
      LMPCS_ADDR_SIZE: reg_view = {12'h000, s.strap_high, s.low_armed,
                                   s.narrow, 1'b0};
      default:         reg_view = 16'h0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == LMPCS_ADDR_LOW) || (a == LMPCS_ADDR_PER) ||
                (a == LMPCS_ADDR_MID) || (a == LMPCS_ADDR_AUX) ||
                (a == LMPCS_ADDR_SIZE);
  endfunction

  // merge a write into a register under lane strobes and mask
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0]  strb,
                                        input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (d & lanes);
  endfunction

  // ****************
  // next-state logic
  // ****************
  // bus slave, configuration, pin sampling and address decode
  always_comb begin
    logic        do_wr;
    logic        do_rd;
    logic [11:0] wa;
    logic        low_hit;
    logic        mid_hit;
    logic        per_hit;
    logic [6:0]  msize;
    logic [6:0]  mkeep;
    logic [2:0]  pwin;
    logic        space_ok;
    logic        addr_ok;
    logic        pinfn;
    logic        ign;
    logic [3:0]  wsel;
    logic [1:0]  q;
    do_wr    = 1'b0;
    do_rd    = 1'b0;
    wa       = 12'h000;
    low_hit  = 1'b0;
    mid_hit  = 1'b0;
    per_hit  = 1'b0;
    msize    = 7'h00;
    mkeep    = 7'h00;
    pwin     = 3'h0;
    space_ok = 1'b0;
    addr_ok  = 1'b0;
    pinfn    = 1'b0;
    ign      = 1'b1;
    wsel     = 4'h0;
    q        = 2'h0;
    nxt_cur  = cur_ff;

    // write channels are taken in either order, answered after both
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_cur.aw_held = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_cur.w_held = 1'b1;
      nxt_cur.w_data = s_axi_wdata[15:0];
      nxt_cur.w_strb = s_axi_wstrb[1:0];
    end
    if (cur_ff.aw_held && cur_ff.w_held) begin
      do_wr           = 1'b1;
      wa              = cur_ff.aw_addr;
      nxt_cur.aw_held = 1'b0;
      nxt_cur.w_held  = 1'b0;
      nxt_cur.bvalid  = 1'b1;
      nxt_cur.bresp   = is_mapped(wa) ? LMPCS_RESP_OKAY : LMPCS_RESP_SLVERR;
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_cur.bvalid = 1'b0;
    end

    // register writes; a lower or peripheral write arms its group, mid and aux writes each mark theirs seen
    if (do_wr) begin
      case (wa)
        LMPCS_ADDR_LOW: begin
          nxt_cur.low_cfg   = merge(cur_ff.low_cfg, cur_ff.w_data,
                                    cur_ff.w_strb, LMPCS_LOW_WMASK); // R23
          nxt_cur.low_armed = 1'b1; // R1
        end
        LMPCS_ADDR_PER: begin
          nxt_cur.per_cfg   = merge(cur_ff.per_cfg, cur_ff.w_data,
                                    cur_ff.w_strb, LMPCS_PER_WMASK);
          nxt_cur.per_armed = 1'b1;
        end
        LMPCS_ADDR_MID: begin
          nxt_cur.mid_cfg  = merge(cur_ff.mid_cfg, cur_ff.w_data,
                                   cur_ff.w_strb, LMPCS_MID_WMASK);
          nxt_cur.mid_seen = 1'b1; // R9
        end
        LMPCS_ADDR_AUX: begin
          nxt_cur.aux_cfg  = merge(cur_ff.aux_cfg, cur_ff.w_data,
                                   cur_ff.w_strb, LMPCS_AUX_WMASK);
          nxt_cur.aux_seen = 1'b1; // R9
        end
        LMPCS_ADDR_SIZE: begin
          if (cur_ff.w_strb[0]) begin
            nxt_cur.narrow = cur_ff.w_data[LMPCS_SIZE_NARROW_BIT]; // R21
          end
        end
        default: begin
          nxt_cur.narrow = cur_ff.narrow;
        end
      endcase
    end

    // reads answer one cycle after the address is taken; reads arm too
    if (s_axi_arvalid && s_axi_arready) begin
      do_rd          = 1'b1;
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rdata  = {16'h0000, reg_view(cur_ff, s_axi_araddr)};
      nxt_cur.rresp  = is_mapped(s_axi_araddr) ? LMPCS_RESP_OKAY
                                               : LMPCS_RESP_SLVERR;
    end else if (cur_ff.rvalid && s_axi_rready) begin
      nxt_cur.rvalid = 1'b0;
    end
    if (do_rd && s_axi_araddr == LMPCS_ADDR_LOW) begin
      nxt_cur.low_armed = 1'b1; // R1
    end
    if (do_rd && s_axi_araddr == LMPCS_ADDR_PER) begin
      nxt_cur.per_armed = 1'b1;
    end
    if (do_rd && s_axi_araddr == LMPCS_ADDR_MID) begin
      nxt_cur.mid_seen = 1'b1; // R9
    end
    if (do_rd && s_axi_araddr == LMPCS_ADDR_AUX) begin
      nxt_cur.aux_seen = 1'b1; // R9
    end

    // strap caught once the three-stage sampler has settled after reset
    nxt_cur.strap_sync = {cur_ff.strap_sync[1:0], address_enable_strap};
    if (!cur_ff.strap_taken) begin
      if (cur_ff.strap_cnt != LMPCS_STRAP_WAIT) begin
        nxt_cur.strap_cnt = cur_ff.strap_cnt + 2'h1;
      end else if (cur_ff.strap_sync[1] == cur_ff.strap_sync[2]) begin
        nxt_cur.strap_taken = 1'b1;
        nxt_cur.strap_high  = cur_ff.strap_sync[2]; // R4
      end
    end

    // asynchronous ready counts once two late stages agree
    nxt_cur.rdy_sync = {cur_ff.rdy_sync[1:0], async_ready_in};
    if (cur_ff.rdy_sync[1] == cur_ff.rdy_sync[2]) begin
      nxt_cur.rdy_level = cur_ff.rdy_sync[2];
    end

    // lower region: clear address bits above the programmed size
    low_hit = cur_ff.low_armed && !cpu_addr[19] && cpu_is_memory &&
              ((cpu_addr[18:16] &
                ~cur_ff.low_cfg[LMPCS_LOW_SIZE_LSB +: 3]) == 3'h0); // R3

    // mid region: compare base bits above the one-hot block size
    msize   = cur_ff.aux_cfg[LMPCS_MID_SIZE_LSB +: 7]; // R13
    mkeep   = ~(msize - 7'h01);
    mid_hit = cur_ff.mid_seen && cur_ff.aux_seen && cpu_is_memory &&
              (msize != 7'h00) &&
              (((cpu_addr[19:13] ^
                 cur_ff.mid_cfg[15:9]) & mkeep) == 7'h00); // R9 R10
    q       = mid_quarter(msize, cpu_addr); // R13

    // peripheral region: 2K-aligned base, space choice, io limited to 64K
    space_ok = cpu_is_memory == cur_ff.aux_cfg[LMPCS_AUX_SPACE_BIT]; // R15
    if (cur_ff.aux_cfg[LMPCS_AUX_SPACE_BIT]) begin
      addr_ok = cpu_addr[19:11] == cur_ff.per_cfg[15:7]; // R17
    end else begin
      addr_ok = cpu_addr[15:11] == cur_ff.per_cfg[11:7]; // R16
    end
    pinfn   = cur_ff.aux_cfg[LMPCS_AUX_PINFN_BIT];
    pwin    = cpu_addr[10:8];
    per_hit = cur_ff.per_armed && space_ok && addr_ok &&
              ((pwin < 3'h4) || (pinfn && (pwin == 3'h5 || pwin == 3'h6)));

    // selects held low for the whole active cycle; lower wins overlaps
    nxt_cur.low_n = 1'b1;
    nxt_cur.mid_n = 4'hF;
    nxt_cur.per_n = 4'hF;
    nxt_cur.pin65 = pinfn ? 2'h3 : {cpu_addr[2], cpu_addr[1]}; // R14
    if (cpu_cycle_active) begin
      if (low_hit) begin
        nxt_cur.low_n = 1'b0; // R22
        ign  = cur_ff.low_cfg[LMPCS_RDY_IGN_BIT];
        wsel = {2'h0, cur_ff.low_cfg[1:0]}; // R8
      end else if (mid_hit) begin
        nxt_cur.mid_n[q] = 1'b0; // R22
        ign  = cur_ff.mid_cfg[LMPCS_RDY_IGN_BIT];
        wsel = {2'h0, cur_ff.mid_cfg[1:0]}; // R8
      end else if (per_hit && pwin < 3'h4) begin
        nxt_cur.per_n[pwin[1:0]] = 1'b0; // R22
        ign  = cur_ff.per_cfg[LMPCS_RDY_IGN_BIT];
        wsel = per_waits({cur_ff.per_cfg[LMPCS_WAIT_HI_BIT],
                          cur_ff.per_cfg[1:0]}); // R19
      end else if (per_hit) begin
        // bit 0 is pin 5 (upper window), bit 1 is pin 6
        nxt_cur.pin65 = (pwin == 3'h6) ? 2'h2 : 2'h1; // R17 R22
        ign  = cur_ff.aux_cfg[LMPCS_RDY_IGN_BIT];
        wsel = {2'h0, cur_ff.aux_cfg[1:0]}; // R8
      end
    end
    nxt_cur.waits      = wsel;
    // external ready only stretches cycles of groups that require it
    nxt_cur.hold       = !ign &&
                         (cur_ff.rdy_level || sync_ready_in); // R7 R20
    nxt_cur.apoff      = low_hit && cpu_cycle_active && cur_ff.strap_high &&
                         cur_ff.low_cfg[LMPCS_LOW_APOFF_BIT]; // R4
    nxt_cur.narrow_out = cur_ff.narrow && cpu_cycle_active &&
                         !low_hit && (mid_hit || per_hit); // R21
  end

  // ****************
  // state register
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff             <= '0;
      cur_ff.low_cfg     <= LMPCS_CFG_RESET;
      cur_ff.per_cfg     <= LMPCS_CFG_RESET;
      cur_ff.mid_cfg     <= LMPCS_CFG_RESET;
      cur_ff.aux_cfg     <= LMPCS_CFG_RESET;
      cur_ff.low_n       <= 1'b1;
      cur_ff.mid_n       <= 4'hF;
      cur_ff.per_n       <= 4'hF;
      cur_ff.pin65       <= 2'h3;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************
  // outputs
  // ****************
  // handshake readies may be combinational
  assign s_axi_awready         = !cur_ff.aw_held && !cur_ff.bvalid;
  assign s_axi_wready          = !cur_ff.w_held && !cur_ff.bvalid;
  assign s_axi_arready         = !cur_ff.rvalid;
  assign s_axi_bvalid          = cur_ff.bvalid;
  assign s_axi_bresp           = cur_ff.bresp;
  assign s_axi_rvalid          = cur_ff.rvalid;
  assign s_axi_rdata           = cur_ff.rdata;
  assign s_axi_rresp           = cur_ff.rresp;
  assign low_mem_select_n      = cur_ff.low_n;
  assign mid_mem_selects_n     = cur_ff.mid_n;
  assign periph_selects_n      = cur_ff.per_n;
  assign periph_pin65          = cur_ff.pin65;
  assign wait_count            = cur_ff.waits;
  assign ext_wait_hold         = cur_ff.hold;
  assign addr_phase_off        = cur_ff.apoff;
  assign psram_mode_enable     = cur_ff.low_cfg[LMPCS_LOW_PSRAM_BIT]; // R5
  assign mid_periph_narrow_bus = cur_ff.narrow_out;

endmodule // lmpcs_chip_select

// file: hdl/lmpcs_pkg.sv
// Purpose: constants for the lower, mid-range and peripheral select decoder
// Assumes: register indices are printed offsets, byte address is four times
// Notes:   stored masks keep only writable bits, fixed masks give reserved bits
package lmpcs_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [11:0] LMPCS_IDX_LOW  = 12'h00A2;
  localparam logic [11:0] LMPCS_IDX_PER  = 12'h00A4;
  localparam logic [11:0] LMPCS_IDX_MID  = 12'h00A6;
  localparam logic [11:0] LMPCS_IDX_AUX  = 12'h00A8;
  localparam logic [11:0] LMPCS_IDX_SIZE = 12'h00AA;
  localparam logic [11:0] LMPCS_ADDR_LOW  = LMPCS_IDX_LOW  << 2;
  localparam logic [11:0] LMPCS_ADDR_PER  = LMPCS_IDX_PER  << 2;
  localparam logic [11:0] LMPCS_ADDR_MID  = LMPCS_IDX_MID  << 2;
  localparam logic [11:0] LMPCS_ADDR_AUX  = LMPCS_IDX_AUX  << 2;
  localparam logic [11:0] LMPCS_ADDR_SIZE = LMPCS_IDX_SIZE << 2;

  // ****************************************************************
  // writable masks and fixed reserved values
  // ****************************************************************
  localparam logic [15:0] LMPCS_LOW_WMASK = 16'h70C7;
  localparam logic [15:0] LMPCS_LOW_FIXED = 16'h0F38;
  localparam logic [15:0] LMPCS_PER_WMASK = 16'hFF8F;
  localparam logic [15:0] LMPCS_PER_FIXED = 16'h0070;
  localparam logic [15:0] LMPCS_MID_WMASK = 16'hFF87;
  localparam logic [15:0] LMPCS_MID_FIXED = 16'h0078;
  localparam logic [15:0] LMPCS_AUX_WMASK = 16'h7FC7;
  localparam logic [15:0] LMPCS_AUX_FIXED = 16'h8038;
  localparam logic [15:0] LMPCS_CFG_RESET = 16'h0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LMPCS_LOW_SIZE_LSB  = 12;
  localparam int LMPCS_LOW_APOFF_BIT = 7;
  localparam int LMPCS_LOW_PSRAM_BIT = 6;
  localparam int LMPCS_RDY_IGN_BIT   = 2;
  localparam int LMPCS_WAIT_HI_BIT   = 3;
  localparam int LMPCS_BASE_LSB      = 7;
  localparam int LMPCS_MID_SIZE_LSB  = 8;
  localparam int LMPCS_AUX_PINFN_BIT = 7;
  localparam int LMPCS_AUX_SPACE_BIT = 6;
  localparam int LMPCS_SIZE_NARROW_BIT = 1;

  // ****************************************************************
  // bus answers and timing
  // ****************************************************************
  localparam logic [1:0] LMPCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LMPCS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] LMPCS_STRAP_WAIT  = 2'h3;

endpackage

// file: sim/lmpcs_chip_select_assertions.sv
// Purpose: port-level checks for the chip-select decoder
// Assumes: one clock domain, synchronous active-low reset
// Notes:   decode outputs are registered one cycle behind the sample
`timescale 1ns/1ps
module lmpcs_chip_select_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [19:0] cpu_addr,
  input wire logic        cpu_cycle_active,
  input wire logic        cpu_is_memory,
  input wire logic        async_ready_in,
  input wire logic        sync_ready_in,
  input wire logic        low_mem_select_n,
  input wire logic [3:0]  mid_mem_selects_n,
  input wire logic [3:0]  periph_selects_n,
  input wire logic [1:0]  periph_pin65,
  input wire logic [3:0]  wait_count,
  input wire logic        ext_wait_hold,
  input wire logic        addr_phase_off,
  input wire logic        mid_periph_narrow_bus
);
  // ****************
  // decode checks
  // ****************
  logic all_off;
  logic any_mp;

  // no select of the three groups is low
  assign all_off = low_mem_select_n & (&mid_mem_selects_n) &
                   (&periph_selects_n);
  assign any_mp  = ~((&mid_mem_selects_n) & (&periph_selects_n) &
                   (&periph_pin65));

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both ready lines low long enough to cross the sync stages
  sequence quiet_s;
    (!async_ready_in && !sync_ready_in) [*5];
  endsequence

  AST_RST_IDLE: assert property (!$past(aresetn) |-> all_off)
    else $error("select low right after reset");
  AST_IDLE_OFF: assert property (!cpu_cycle_active |=> all_off)
    else $error("select low outside a bus cycle");
  AST_LOW_TOP: assert property (cpu_addr[19] |=> low_mem_select_n)
    else $error("lower select above its region");
  AST_IO_NOMEM: assert property (!cpu_is_memory |=>
    low_mem_select_n && (&mid_mem_selects_n))
    else $error("memory select on an io cycle");
  AST_MID_ONE: assert property ($onehot0(~mid_mem_selects_n) &&
    (low_mem_select_n || (&mid_mem_selects_n)))
    else $error("mid selects not exclusive");
  AST_WAIT_TWO: assert property (!all_off &&
    (&periph_selects_n) |-> wait_count < 4'h4)
    else $error("two-bit wait above three");
  AST_WAIT_CODES: assert property
    (!(wait_count inside {4'h4, 4'h6, 4'h8, [4'hA:4'hE]}))
    else $error("wait count not a legal value");
  AST_APOFF: assert property (addr_phase_off |-> !low_mem_select_n)
    else $error("address phase off without lower select");
  AST_NARROW: assert property (mid_periph_narrow_bus |-> any_mp)
    else $error("narrow bus outside mid or peripheral cycle");
  AST_READY: assert property (quiet_s |=> !ext_wait_hold)
    else $error("wait hold without external ready");
endmodule // lmpcs_chip_select_checker

bind lmpcs_chip_select lmpcs_chip_select_checker u_chk (.*);

// file: sim/lmpcs_chip_select_tb.sv
// Purpose: register and decode scenarios for the chip-select decoder
// Assumes: 20 MHz clock, strap held high, ready lines from device model
// Notes:   each transfer waits on its handshake, a watchdog cuts hangs
`timescale 1ns/1ps
module lmpcs_chip_select_tb;
  import lmpcs_pkg::*;
  // ****************
  // signals, clock and instances
  // ****************
  logic        aclk, aresetn, slow, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        cpu_cycle_active, cpu_is_memory, address_enable_strap;
  logic        async_ready_in, sync_ready_in, low_mem_select_n;
  logic        ext_wait_hold, addr_phase_off, psram_mode_enable;
  logic        mid_periph_narrow_bus;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, mid_mem_selects_n, periph_selects_n, wait_count;
  logic [1:0]  s_axi_bresp, s_axi_rresp, periph_pin65;
  logic [19:0] cpu_addr;
  logic [3:0]  wt [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hF};
  int          n_mismatch, cmp_count, i;

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  lmpcs_chip_select DUT (.*);
  lmpcs_ext_device u_dev (.*);

  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
  endtask

  task rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {16'h0000, e}, "read data");
    chk(s_axi_rresp, er, "read response");
  endtask

  // one bus cycle, then the registered selects and wait count
  task cyc(input logic [19:0] a, input logic m, input logic [8:0] es,
           input logic [3:0] ew);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_is_memory <= m;
    cpu_cycle_active <= 1'b1;
    @(posedge aclk);
    cpu_cycle_active <= 1'b0;
    #1;
    chk({low_mem_select_n, mid_mem_selects_n, periph_selects_n}, es,
        "selects");
    if (es != 9'h1FF) chk(wait_count, ew, "wait count");
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    aresetn = 1'b0; slow = 1'b0; address_enable_strap = 1'b1;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    cpu_addr = 20'h0_0000; cpu_cycle_active = 1'b0; cpu_is_memory = 1'b0;
    n_mismatch = 0; cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(20'h0_1234, 1'b1, 9'h1FF, 4'h0);
    rd(LMPCS_ADDR_LOW, 16'h0F38, LMPCS_RESP_OKAY);
    cyc(20'h0_1234, 1'b1, 9'h0FF, 4'h0);
    rd(12'h100, 16'h0000, LMPCS_RESP_SLVERR);
    wr(12'h104, 16'h0000, LMPCS_RESP_SLVERR);
    $display("test arming done");
    for (i = 0; i < 4; i++) begin
      wr(LMPCS_ADDR_LOW, {1'b0, 3'((1 << i) - 1), 9'h000, 1'b1, i[1:0]},
         LMPCS_RESP_OKAY);
      cyc({1'b0, 3'((1 << i) - 1), 16'hFFFF}, 1'b1, 9'h0FF, 4'(i));
      cyc({1'b0, 3'((1 << i) - 1), 16'hFFFF} + 20'h0_0001, 1'b1, 9'h1FF,
          4'h0);
    end
    @(posedge aclk);
    slow <= 1'b1;
    wr(LMPCS_ADDR_LOW, 16'h7000, LMPCS_RESP_OKAY);
    cyc(20'h0_0100, 1'b1, 9'h0FF, 4'h0);
    chk(ext_wait_hold, 1'h1, "ready required");
    wr(LMPCS_ADDR_LOW, 16'h7004, LMPCS_RESP_OKAY);
    cyc(20'h0_0100, 1'b1, 9'h0FF, 4'h0);
    chk(ext_wait_hold, 1'h0, "ready ignored");
    @(posedge aclk);
    slow <= 1'b0;
    $display("test lower range done");
    wr(LMPCS_ADDR_LOW, 16'h70C4, LMPCS_RESP_OKAY);
    rd(LMPCS_ADDR_LOW, 16'h7FFC, LMPCS_RESP_OKAY);
    cyc(20'h0_0100, 1'b1, 9'h0FF, 4'h0);
    chk(addr_phase_off, 1'h1, "address off");
    chk(psram_mode_enable, 1'h1, "psram on");
    wr(LMPCS_ADDR_LOW, 16'hFFFF, LMPCS_RESP_OKAY);
    rd(LMPCS_ADDR_LOW, 16'h7FFF, LMPCS_RESP_OKAY);
    wr(LMPCS_ADDR_LOW, 16'h7004, LMPCS_RESP_OKAY);
    cyc(20'h0_0100, 1'b1, 9'h0FF, 4'h0);
    chk(addr_phase_off, 1'h0, "address on");
    chk(psram_mode_enable, 1'h0, "psram off");
    $display("test lower options done");
    wr(LMPCS_ADDR_MID, 16'h8007, LMPCS_RESP_OKAY);
    cyc(20'h8_0000, 1'b1, 9'h1FF, 4'h0);
    rd(LMPCS_ADDR_MID, 16'h807F, LMPCS_RESP_OKAY);
    rd(LMPCS_ADDR_AUX, 16'h8038, LMPCS_RESP_OKAY);
    wr(LMPCS_ADDR_AUX, 16'h0484, LMPCS_RESP_OKAY);
    for (i = 0; i < 5; i++)
      cyc(20'h8_0000 + 20'(i * 32'h0000_2000), 1'b1, (i < 4) ?
          {1'b1, ~(4'h1 << i), 4'hF} : 9'h1FF, 4'h3);
    wr(LMPCS_ADDR_SIZE, 16'h0002, LMPCS_RESP_OKAY);
    cyc(20'h8_0000, 1'b1, 9'h1EF, 4'h3);
    chk(mid_periph_narrow_bus, 1'h1, "narrow mid");
    cyc(20'h0_0100, 1'b1, 9'h0FF, 4'h0);
    chk(mid_periph_narrow_bus, 1'h0, "narrow low");
    $display("test mid range done");
    for (i = 0; i < 8; i++) begin
      wr(LMPCS_ADDR_PER, 16'h0104 | {12'h000, i[2], 1'b0, i[1:0]},
         LMPCS_RESP_OKAY);
      cyc({8'h01, 2'b00, i[1:0], 8'h00}, 1'b0, {5'h1F, ~(4'h1 << i[1:0])},
          wt[i]);
    end
    cyc(20'h1_1300, 1'b0, 9'h1F7, 4'hF);
    cyc(20'h0_1500, 1'b0, 9'h1FF, 4'h0);
    chk(periph_pin65, 2'h1, "pin six select");
    cyc(20'h0_1600, 1'b0, 9'h1FF, 4'h0);
    chk(periph_pin65, 2'h2, "pin five select");
    wr(LMPCS_ADDR_AUX, 16'h0404, LMPCS_RESP_OKAY);
    cyc(20'h0_0006, 1'b0, 9'h1FF, 4'h0);
    chk(periph_pin65, 2'h3, "pins as address");
    cyc(20'h0_0002, 1'b0, 9'h1FF, 4'h0);
    chk(periph_pin65, 2'h1, "pins as address");
    wr(LMPCS_ADDR_AUX, 16'h04C4, LMPCS_RESP_OKAY);
    cyc(20'h0_1000, 1'b0, 9'h1FF, 4'h0);
    wr(LMPCS_ADDR_PER, 16'hA004, LMPCS_RESP_OKAY);
    cyc(20'hA_0000, 1'b1, 9'h1FE, 4'h0);
    $display("test peripheral done");
    finish_test;
  end

  // watchdog well beyond the few hundred cycles of the scenarios
  initial begin
    #500_000;
    n_mismatch++;
    finish_test;
  end
endmodule // lmpcs_chip_select_tb

// file: sim/lmpcs_ext_device.sv
// Purpose: memory and peripheral side model driving the ready inputs
// Assumes: slow picks a device that stretches every access
// Notes:   ready high asks for waits, both stay low for a prompt device
`timescale 1ns/1ps
module lmpcs_ext_device (
  input  wire logic       aclk,
  input  wire logic       slow,
  input  wire logic       low_mem_select_n,
  input  wire logic [3:0] mid_mem_selects_n,
  input  wire logic [3:0] periph_selects_n,
  output logic            async_ready_in = 1'b0,
  output logic            sync_ready_in = 1'b0
);
  // ****************
  // ready answer
  // ****************
  // slow device: pin ready held high, same-clock ready while selected
  always @(posedge aclk) begin
    async_ready_in <= slow;
    sync_ready_in  <= slow & ~(low_mem_select_n & (&mid_mem_selects_n) &
                      (&periph_selects_n));
  end
endmodule // lmpcs_ext_device
